// [common/bsa_pkg.sv]
package bsa_pkg;

  // Wishbone byte addresses of the register words
  localparam logic [7:0] BSA_ADR_ACC  = 8'h00;
  localparam logic [7:0] BSA_ADR_STK  = 8'h04;
  localparam logic [7:0] BSA_ADR_DISC = 8'h08;
  localparam logic [7:0] BSA_ADR_FMT  = 8'h0c;
  localparam logic [7:0] BSA_ADR_CMD  = 8'h10;
  localparam logic [7:0] BSA_ADR_FLG  = 8'h14;

  // Format register fields: first discrete bit and bit count
  localparam int unsigned BSA_FMT_START_LSB = 0;
  localparam int unsigned BSA_FMT_COUNT_LSB = 8;
  localparam logic [4:0]  BSA_FMT_COUNT_MAX = 5'h10;

  localparam int unsigned BSA_STACK_DEPTH = 8;

  localparam logic [31:0] BSA_ACC_RST  = 32'h0000_0000;
  localparam logic [31:0] BSA_DISC_RST = 32'h0000_0000;
  localparam logic [15:0] BSA_FMT_RST  = 16'h1000;

  localparam logic [31:0] BSA_DEC8_LIMIT = 32'h05f5_e100;
  localparam logic [31:0] BSA_DEC4_LIMIT = 32'h0000_2710;

  typedef enum logic [3:0] {
    BSA_OP_NONE,
    BSA_OP_ADD_BCD,
    BSA_OP_SUB_BCD,
    BSA_OP_MUL_BCD,
    BSA_OP_DIV_BCD,
    BSA_OP_ADD_BIN,
    BSA_OP_SUB_BIN,
    BSA_OP_DIV_FMT
  } bsa_op_t;

  typedef struct packed {
    logic invalid_bcd_flag;
    logic sign_error_flag;
    logic negative_result_flag;
    logic carry32_flag;
    logic carry16_flag;
    logic borrow32_flag;
    logic borrow16_flag;
    logic zero_result_flag;
    logic operand_overflow_flag;
  } bsa_flags_t;

  localparam bsa_flags_t BSA_FLAGS_RST = '0;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } bsa_wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } bsa_wb_rsp_t;

endpackage

// [rtl/bsa_stack_arith.sv]
`timescale 1ns/10ps
module bsa_stack_arith #(
  parameter int unsigned STACK_DEPTH = bsa_pkg::BSA_STACK_DEPTH
) (
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire bsa_pkg::bsa_wb_req_t wb_req_i,
  output bsa_pkg::bsa_wb_rsp_t      wb_rsp_o,
  output logic [31:0]              acc_o,
  output logic [31:0]              stack_top_o,
  output bsa_pkg::bsa_flags_t      flags_o
);
  import bsa_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Decimal helpers

  function automatic logic [31:0] bcd2bin(input logic [31:0] v);
    logic [31:0] r;
    r = 32'h0;
    for (int i = 7; i >= 0; i--)
    begin
      r = r * 32'd10 + {28'h0, v[4*i +: 4]};
    end
    return r;
  endfunction

  function automatic logic [31:0] bin2bcd(input logic [26:0] v);
    logic [58:0] w;
    w = {32'h0, v};
    for (int i = 0; i < 27; i++)
    begin
      for (int j = 0; j < 8; j++)
      begin
        if (w[27+4*j +: 4] > 4'h4)
        begin
          w[27+4*j +: 4] = w[27+4*j +: 4] + 4'h3;
        end
      end
      w = w << 1;
    end
    return w[58:27];
  endfunction

  function automatic logic bcd_ok(input logic [31:0] v);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      if (v[4*i +: 4] > 4'h9)
      begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++)
    begin
      if (s[i])
      begin
        r[8*i +: 8] = n[8*i +: 8];
      end
    end
    return r;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // State

  logic [31:0] acc_q,  acc_d;
  logic [31:0] disc_q;
  logic [15:0] fmt_q;
  bsa_op_t     last_op_q;
  bsa_flags_t  flags_q, flags_d;
  logic        ack_q;
  logic [31:0] rdat_q;
  logic [31:0] stk_q    [STACK_DEPTH];
  logic [31:0] stk_d    [STACK_DEPTH];
  logic [31:0] stk_push [STACK_DEPTH];
  logic [31:0] stk_pop  [STACK_DEPTH];
  logic [31:0] stk_rem  [STACK_DEPTH];

  //////////////////////////////////////////////////////////////////////////////
  // Wishbone slave: ack one cycle after the strobe; the write lands on the
  // edge where the master sees ack, so a held request acts exactly once.

  wire       bus_req  = wb_req_i.cyc & wb_req_i.stb;
  wire       wr_fire  = bus_req & wb_req_i.we & ack_q;
  wire       wr_acc   = wr_fire & (wb_req_i.adr == BSA_ADR_ACC);
  wire       wr_disc  = wr_fire & (wb_req_i.adr == BSA_ADR_DISC);
  wire       wr_fmt   = wr_fire & (wb_req_i.adr == BSA_ADR_FMT);
  wire       wr_cmd   = wr_fire & (wb_req_i.adr == BSA_ADR_CMD) & wb_req_i.sel[0];
  wire [31:0] acc_wr  = merge(acc_q, wb_req_i.dat, wb_req_i.sel);
  wire [31:0] disc_wr = merge(disc_q, wb_req_i.dat, wb_req_i.sel);
  wire [31:0] fmt_wr  = merge({16'h0, fmt_q}, wb_req_i.dat, wb_req_i.sel);
  wire bsa_op_t op    = wr_cmd ? bsa_op_t'(wb_req_i.dat[3:0]) : BSA_OP_NONE;

  logic [31:0] rd_mux;
  always_comb
  begin
    unique case (wb_req_i.adr)
      BSA_ADR_ACC:  rd_mux = acc_q;
      BSA_ADR_STK:  rd_mux = stk_q[0];
      BSA_ADR_DISC: rd_mux = disc_q;
      BSA_ADR_FMT:  rd_mux = {16'h0, fmt_q};
      BSA_ADR_CMD:  rd_mux = {28'h0, last_op_q};
      BSA_ADR_FLG:  rd_mux = {23'h0, flags_q};
      default:      rd_mux = 32'h0;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Operands

  wire [4:0]  fmt_start = fmt_q[BSA_FMT_START_LSB +: 5];
  wire [4:0]  fmt_raw   = fmt_q[BSA_FMT_COUNT_LSB +: 5];
  // Counts above sixteen are clamped; a zero count reads as one bit
  wire [4:0]  fmt_cnt   = (fmt_raw > BSA_FMT_COUNT_MAX) ? BSA_FMT_COUNT_MAX :
                          (fmt_raw == 5'h0) ? 5'h1 : fmt_raw;
  wire [31:0] fmt_shift = disc_q >> fmt_start;
  wire [31:0] fmt_mask  = ~(32'hffff_ffff << fmt_cnt);
  wire [31:0] fmt_val   = fmt_shift & fmt_mask;

  wire [31:0] a    = acc_q;
  wire [31:0] b    = stk_q[0];
  wire [31:0] a_d  = bcd2bin(a);
  wire [31:0] b_d  = bcd2bin(b);
  wire [31:0] a_lo = bcd2bin({16'h0, a[15:0]});
  wire [31:0] b_lo = bcd2bin({16'h0, b[15:0]});
  wire        ok_a = bcd_ok(a);
  wire        ok_b = bcd_ok(b);

  //////////////////////////////////////////////////////////////////////////////
  // BCD add and subtract on eight digits

  wire [31:0] dsum  = a_d + b_d;
  wire        dcy32 = dsum >= BSA_DEC8_LIMIT;
  wire        dcy16 = (a_lo + b_lo) >= BSA_DEC4_LIMIT;
  wire [31:0] dsum8 = dcy32 ? dsum - BSA_DEC8_LIMIT : dsum;
  wire [31:0] add_bcd = bin2bcd(dsum8[26:0]);

  wire        dbw32 = a_d < b_d;
  wire        dbw16 = a_lo < b_lo;
  // A borrow leaves the ten's complement, as an eight-digit counter would
  wire [31:0] ddif  = dbw32 ? a_d + BSA_DEC8_LIMIT - b_d : a_d - b_d;
  wire [31:0] sub_bcd = bin2bcd(ddif[26:0]);

  // Four digits each, so the product always fits eight digits
  wire [31:0] dprod   = a_lo * b_lo;
  wire [31:0] mul_bcd = bin2bcd(dprod[26:0]);
  wire        ok_mul  = bcd_ok({16'h0, a[15:0]}) & bcd_ok({16'h0, b[15:0]});

  //////////////////////////////////////////////////////////////////////////////
  // Shared decimal divider for the stack and formatted divides

  wire        is_fmt  = (op == BSA_OP_DIV_FMT);
  wire [31:0] dv_src  = is_fmt ? fmt_val : b;
  wire [31:0] dv      = bcd2bin({16'h0, dv_src[15:0]});
  // A divisor over four digits or zero cannot divide the accumulator
  wire        dv_ovf  = (dv_src[31:16] != 16'h0) | (dv == 32'h0);
  wire [31:0] dv_safe = dv_ovf ? 32'h1 : dv;
  wire [31:0] quo     = a_d / dv_safe;
  wire [31:0] rem     = a_d % dv_safe;
  wire [31:0] quo_bcd = bin2bcd(quo[26:0]);
  wire [31:0] rem_bcd = bin2bcd(rem[26:0]);
  wire        ok_div  = ok_a & bcd_ok(dv_src);

  //////////////////////////////////////////////////////////////////////////////
  // Binary add and subtract

  wire [32:0] bsum  = {1'b0, a} + {1'b0, b};
  wire [16:0] bs16  = {1'b0, a[15:0]} + {1'b0, b[15:0]};
  wire [31:0] bdif  = a - b;
  wire        bsadd = (a[31] == b[31]) & (bsum[31] != a[31]);
  wire        bssub = (a[31] != b[31]) & (bdif[31] != a[31]);

  //////////////////////////////////////////////////////////////////////////////
  // Flags owned by each operation; a mask bit per struct field, overflow at bit 0

  localparam bsa_flags_t UPD_ADD_BCD = 9'h1f2;
  localparam bsa_flags_t UPD_SUB_BCD = 9'h1ce;
  localparam bsa_flags_t UPD_MUL_BCD = 9'h142;
  localparam bsa_flags_t UPD_DIV     = 9'h143;
  localparam bsa_flags_t UPD_ADD_BIN = 9'h0f2;
  localparam bsa_flags_t UPD_SUB_BIN = 9'h0ce;

  //////////////////////////////////////////////////////////////////////////////
  // Result and flag selection

  logic        pop, keep_rem;
  logic [31:0] res;
  bsa_flags_t  fv, upd;

  always_comb
  begin
    pop      = 1'b0;
    keep_rem = 1'b0;
    res      = acc_q;
    fv       = '0;
    upd      = '0;
    unique case (op)
      BSA_OP_ADD_BCD:
      begin
        pop                 = 1'b1;
        res                 = add_bcd;
        fv.carry16_flag     = dcy16;
        fv.carry32_flag     = dcy32;
        fv.sign_error_flag  = (a[31] == b[31]) & (add_bcd[31] != a[31]);
        fv.invalid_bcd_flag = ~(ok_a & ok_b);
        upd                 = UPD_ADD_BCD;
      end
      BSA_OP_SUB_BCD:
      begin
        pop                 = 1'b1;
        res                 = sub_bcd;
        fv.borrow16_flag    = dbw16;
        fv.borrow32_flag    = dbw32;
        fv.sign_error_flag  = (a[31] != b[31]) & (sub_bcd[31] != a[31]);
        fv.invalid_bcd_flag = ~(ok_a & ok_b);
        upd                 = UPD_SUB_BCD;
      end
      BSA_OP_MUL_BCD:
      begin
        pop                 = 1'b1;
        res                 = mul_bcd;
        fv.invalid_bcd_flag = ~ok_mul;
        upd                 = UPD_MUL_BCD;
      end
      BSA_OP_DIV_BCD, BSA_OP_DIV_FMT:
      begin
        keep_rem                 = ~dv_ovf;
        res                      = dv_ovf ? acc_q : quo_bcd;
        fv.operand_overflow_flag = dv_ovf;
        fv.invalid_bcd_flag      = ~ok_div;
        upd                      = UPD_DIV;
      end
      BSA_OP_ADD_BIN:
      begin
        pop                = 1'b1;
        res                = bsum[31:0];
        fv.carry16_flag    = bs16[16];
        fv.carry32_flag    = bsum[32];
        fv.sign_error_flag = bsadd;
        upd                = UPD_ADD_BIN;
      end
      BSA_OP_SUB_BIN:
      begin
        pop                = 1'b1;
        res                = bdif;
        fv.borrow16_flag   = a[15:0] < b[15:0];
        fv.borrow32_flag   = a < b;
        fv.sign_error_flag = bssub;
        upd                = UPD_SUB_BIN;
      end
      default:
      begin
        res = acc_q;
      end
    endcase
    fv.zero_result_flag     = (res == 32'h0);
    fv.negative_result_flag = res[31];
  end

  // Untouched flags keep their last value until an owning operation runs
  assign flags_d = (flags_q & ~upd) | (fv & upd);
  assign acc_d   = wr_acc ? acc_wr : res;

  //////////////////////////////////////////////////////////////////////////////
  // Accumulator stack

  genvar gi;
  generate
    for (gi = 0; gi < STACK_DEPTH; gi++)
    begin : g_stk
      if (gi == 0)
      begin : g_top
        assign stk_push[gi] = acc_q;
        assign stk_rem[gi]  = rem_bcd;
      end
      else
      begin : g_low
        assign stk_push[gi] = stk_q[gi-1];
        assign stk_rem[gi]  = stk_q[gi];
      end
      if (gi == STACK_DEPTH - 1)
      begin : g_bot
        assign stk_pop[gi] = 32'h0;
      end
      else
      begin : g_mid
        assign stk_pop[gi] = stk_q[gi+1];
      end
      assign stk_d[gi] = wr_acc   ? stk_push[gi] :
                         pop      ? stk_pop[gi]  :
                         keep_rem ? stk_rem[gi]  : stk_q[gi];
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      acc_q     <= BSA_ACC_RST;
      disc_q    <= BSA_DISC_RST;
      fmt_q     <= BSA_FMT_RST;
      last_op_q <= BSA_OP_NONE;
      flags_q   <= BSA_FLAGS_RST;
      ack_q     <= 1'b0;
      rdat_q    <= 32'h0;
      for (int i = 0; i < STACK_DEPTH; i++)
      begin
        stk_q[i] <= 32'h0;
      end
    end
    else
    begin
      acc_q   <= acc_d;
      flags_q <= flags_d;
      stk_q   <= stk_d;
      ack_q   <= bus_req & ~ack_q;
      rdat_q  <= rd_mux;
      if (wr_disc)
      begin
        disc_q <= disc_wr;
      end
      if (wr_fmt)
      begin
        fmt_q <= fmt_wr[15:0];
      end
      if (wr_cmd)
      begin
        last_op_q <= op;
      end
    end
  end

  assign wb_rsp_o.ack = ack_q;
  assign wb_rsp_o.dat = rdat_q;
  assign acc_o        = acc_q;
  assign stack_top_o  = stk_q[0];
  assign flags_o      = flags_q;

endmodule // bsa_stack_arith

// [verification/bsa_seq_model.sv]
`timescale 1ns/10ps
// Sequencer side of the register bus: one classic cycle per call
module bsa_seq_model (
  input  wire logic            clk_i,
  input  bsa_pkg::bsa_wb_rsp_t wb_rsp_i,
  output bsa_pkg::bsa_wb_req_t wb_req_o
);
  import bsa_pkg::*;
  initial wb_req_o = '0;
  ////////////////////////////////////////////////////////////////
  // Request held until ack is seen; the bound only guards a hang
  task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] wdat,
                      output logic [31:0] rdat, output logic ok);
    int n;
    @(posedge clk_i);
    wb_req_o <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: wdat};
    ok = 1'b0;
    for (n = 0; n < 20 && !ok; n++)
    begin
      @(posedge clk_i);
      ok = (wb_rsp_i.ack === 1'b1);
    end
    rdat = wb_rsp_i.dat;
    wb_req_o <= '0;
    @(posedge clk_i);
  endtask
endmodule // bsa_seq_model

// [verification/bsa_stack_arith_properties.sv]
`timescale 1ns/10ps
module bsa_stack_arith_properties #(
  parameter int unsigned STACK_DEPTH = 8
) (
  input wire logic                 clk_i,
  input wire logic                 rst_i,
  input wire bsa_pkg::bsa_wb_req_t wb_req_i,
  input wire bsa_pkg::bsa_wb_rsp_t wb_rsp_o,
  input wire logic [31:0]          acc_o,
  input wire logic [31:0]          stack_top_o,
  input wire bsa_pkg::bsa_flags_t  flags_o
);
  import bsa_pkg::*;
  wire       tk     = wb_req_i.cyc & wb_req_i.stb & wb_rsp_o.ack;
  wire       wr     = tk & wb_req_i.we;
  wire       wr_cmd = wr & (wb_req_i.adr == BSA_ADR_CMD) & wb_req_i.sel[0];
  wire       wr_acc = wr & (wb_req_i.adr == BSA_ADR_ACC) & (wb_req_i.sel == 4'hf);
  wire [3:0] opc    = wb_req_i.dat[3:0];
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////
  property p_ack_lat; wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack |=> wb_rsp_o.ack; endproperty
  a_ack_lat: assert property (p_ack_lat) else $error("ack late");
  property p_ack_pulse; wb_rsp_o.ack |=> !wb_rsp_o.ack; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_hold; !wr_cmd |=> $stable(flags_o); endproperty
  a_hold: assert property (p_hold) else $error("flags moved");
  property p_zero; wr_cmd && opc inside {[1:7]} |=> flags_o.zero_result_flag == (acc_o == '0);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag");
  property p_neg; wr_cmd && opc inside {[1:7]} |=> flags_o.negative_result_flag == acc_o[31];
  endproperty
  a_neg: assert property (p_neg) else $error("negative flag");
  property p_load; wr_acc |=> stack_top_o == $past(acc_o) && acc_o == $past(wb_req_i.dat);
  endproperty
  a_load: assert property (p_load) else $error("load push");
  property p_badd;
    wr_cmd && opc == 4'h5 |=> acc_o == $past(acc_o) + $past(stack_top_o)
      && flags_o.carry32_flag == (acc_o < $past(acc_o));
  endproperty
  a_badd: assert property (p_badd) else $error("binary add");
  property p_bsub;
    wr_cmd && opc == 4'h6 |=> acc_o == $past(acc_o) - $past(stack_top_o)
      && flags_o.borrow32_flag == ($past(acc_o) < $past(stack_top_o));
  endproperty
  a_bsub: assert property (p_bsub) else $error("binary subtract");
  property p_ovf;
    wr_cmd && opc == 4'h4 && (stack_top_o[31:16] != '0 || stack_top_o[15:0] == '0)
      |=> flags_o.operand_overflow_flag && $stable(acc_o) && $stable(stack_top_o);
  endproperty
  a_ovf: assert property (p_ovf) else $error("divide overflow");
  property p_stk_ro; wr && wb_req_i.adr == BSA_ADR_STK |=> $stable(stack_top_o); endproperty
  a_stk_ro: assert property (p_stk_ro) else $error("stack written");
endmodule // bsa_stack_arith_properties

bind bsa_stack_arith bsa_stack_arith_properties #(.STACK_DEPTH(STACK_DEPTH))
  bsa_stack_arith_properties_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i),
  .wb_rsp_o(wb_rsp_o), .acc_o(acc_o), .stack_top_o(stack_top_o), .flags_o(flags_o));

// [verification/testbench.sv]
`timescale 1ns/10ps
module testbench;
  import bsa_pkg::*;
  logic        clk_i;
  logic        rst_i = 1'b1;
  bsa_wb_req_t wb_req;
  bsa_wb_rsp_t wb_rsp;
  logic [31:0] acc;
  logic [31:0] stk;
  bsa_flags_t  flg;
  int          n_errors = 0;
  int          checked = 0;
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  bsa_stack_arith bsa_stack_arith_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req),
    .wb_rsp_o(wb_rsp), .acc_o(acc), .stack_top_o(stk), .flags_o(flg));
  bsa_seq_model bsa_seq_model_inst (.clk_i(clk_i), .wb_rsp_i(wb_rsp), .wb_req_o(wb_req));
  ////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    $display("Checks %0d, errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR %0t %s: saw %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                      output logic [31:0] rd);
    logic ok;
    bsa_seq_model_inst.xfer(we, adr, wd, rd, ok);
    if (!ok)
    begin
      n_errors++;
      $display("ERROR %0t bus answer missing", $time);
      print_verdict();
    end
  endtask
  task automatic wr(input logic [7:0] adr, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, adr, d, r);
  endtask
  // Two loads leave a in level one and b in the accumulator
  task automatic ld2(input logic [31:0] a, input logic [31:0] b, input logic [3:0] op);
    wr(BSA_ADR_ACC, a);
    wr(BSA_ADR_ACC, b);
    wr(BSA_ADR_CMD, {28'h0, op});
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic s_reset;
    logic [7:0]  adr [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h14, 8'h1c};
    logic [31:0] exp [6] = '{32'h0, 32'h0, 32'h0, 32'h1000, 32'h0, 32'h0};
    logic [31:0] r;
    wr(BSA_ADR_STK, 32'h1ff);
    wr(8'h1c, 32'h5);
    for (int i = 0; i < 6; i++)
    begin
      xfer(1'b0, adr[i], 32'h0, r);
      check(r, exp[i], "reset read");
    end
  endtask
  task automatic s_stack;
    for (int i = 1; i <= 9; i++)
      wr(BSA_ADR_ACC, i);
    for (int i = 1; i <= 8; i++)
    begin
      wr(BSA_ADR_CMD, 32'h5);
      if (i == 7)
        check(stk, 32'h1, "level one after shifts");
    end
    check(acc, 32'd45, "sum of stack");
    check(stk, 32'h0, "zero fill, bottom dropped");
  endtask
  task automatic s_bcd_add;
    ld2(32'h9999, 32'h1, 4'h1);
    check(acc, 32'h0001_0000, "bcd sum");
    check({flg.carry16_flag, flg.carry32_flag}, 2'b10, "carries");
    ld2(32'h9999_9999, 32'h1, 4'h1);
    check({flg.carry32_flag, flg.zero_result_flag}, 2'b11, "carry32 zero");
    ld2(32'h0a, 32'h1, 4'h1);
    check(flg.invalid_bcd_flag, 1'b1, "non decimal");
  endtask
  task automatic s_bcd_sub_mul;
    ld2(32'h1, 32'h100, 4'h2);
    check(acc, 32'h99, "bcd difference");
    check(flg.invalid_bcd_flag, 1'b0, "flag replaced");
    ld2(32'h2, 32'h1, 4'h2);
    check(acc, 32'h9999_9999, "ten's complement");
    check({flg.borrow16_flag, flg.borrow32_flag}, 2'b11, "borrows");
    ld2(32'h1234, 32'h2, 4'h3);
    check(acc, 32'h2468, "bcd product");
    check(flg.borrow32_flag, 1'b1, "borrow kept");
  endtask
  task automatic s_divide;
    logic [31:0] r;
    ld2(32'h7, 32'h100, 4'h4);
    check(acc, 32'h14, "quotient");
    check(stk, 32'h2, "remainder");
    ld2(32'h0, 32'h5, 4'h4);
    check(acc, 32'h5, "zero divisor keeps acc");
    check(flg.operand_overflow_flag, 1'b1, "zero divisor");
    check(stk, 32'h0, "zero divisor keeps level one");
    wr(BSA_ADR_DISC, 32'h0000_0300);
    wr(BSA_ADR_FMT, 32'h0000_0408);
    wr(BSA_ADR_ACC, 32'h10);
    wr(BSA_ADR_CMD, 32'h7);
    check(acc, 32'h3, "formatted quotient");
    check(stk, 32'h1, "formatted remainder");
    check(flg.operand_overflow_flag, 1'b0, "overflow cleared");
    xfer(1'b0, BSA_ADR_CMD, 32'h0, r);
    check(r, 32'h7, "last opcode read back");
  endtask
  task automatic s_binary;
    logic [31:0] r;
    ld2(32'h1, 32'h7fff_ffff, 4'h5);
    check({flg.sign_error_flag, flg.negative_result_flag}, 2'b11, "sign wrap");
    ld2(32'h1, 32'h0000_ffff, 4'h5);
    check(acc, 32'h1_0000, "carry16 sum");
    check(flg.carry16_flag, 1'b1, "carry16");
    ld2(32'h5, 32'h3, 4'h6);
    check(acc, 32'hffff_fffe, "binary difference");
    check({flg.borrow32_flag, flg.sign_error_flag}, 2'b10, "borrow32");
    wr(BSA_ADR_CMD, 32'h0);
    check(acc, 32'hffff_fffe, "no-op keeps acc");
    xfer(1'b0, BSA_ADR_FLG, 32'h0, r);
    check(r, 32'h0000_005c, "flag word, carry16 held");
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    s_reset();
    s_stack();
    s_bcd_add();
    s_bcd_sub_mul();
    s_divide();
    s_binary();
    print_verdict();
  end
endmodule // testbench
